// File: hdl/tsw_pkg.sv
// Purpose: shared constants for the skip-test and table-write execution block
// Assumes: 16-bit instruction words, 12-bit data addresses, 21-bit table pointer
// Notes: encodings and address split points are defined here; the assertions repeat 5Fh, the bank values and the step as literals
package tsw_pkg;
	localparam int DATA_AW = 12;
	localparam int PTR_W = 21;
	localparam logic [6:0] SKIP_OPC = 7'h33;
	localparam logic [11:0] TBLWR_OPC = 12'h003;
	localparam logic [1:0] TW_PLAIN = 2'h0;
	localparam logic [1:0] TW_POSTINC = 2'h1;
	localparam logic [1:0] TW_POSTDEC = 2'h2;
	localparam logic [1:0] TW_PREINC = 2'h3;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [7:0] INDEX_LIMIT = 8'h5f;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [PTR_W-1:0] PTR_STEP = 21'h000001;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_SKIP = 2'b10
	} exec_state_t;
endpackage

// File: hdl/addr_res_if.sv
// Purpose: carries the operand address request and its resolved data address
// Assumes: resolver is purely combinational
// Notes: one modport per side
`timescale 1ns/1ps
interface addr_res_if;
	logic [7:0] fileAddr;
	logic accessBit;
	logic [3:0] bankSelectReg;
	logic extEnable;
	logic [tsw_pkg::DATA_AW-1:0] indexBase;
	logic [tsw_pkg::DATA_AW-1:0] dataAddr;
	logic indexed;
	modport resolver (input fileAddr, accessBit, bankSelectReg, extEnable, indexBase, output dataAddr, indexed);
	modport core (output fileAddr, accessBit, bankSelectReg, extEnable, indexBase, input dataAddr, indexed);
endinterface

// File: hdl/operand_addr_resolver.sv
// Purpose: turns an 8-bit file operand and access bit into a data address
// Assumes: access bank split at 80h, indexed mode offsets from the index base
// Notes: combinational only
`timescale 1ns/1ps
module operand_addr_resolver (
	addr_res_if.resolver ar
);
	always_comb begin
		ar.indexed = 1'b0;
		if (ar.accessBit) begin
			ar.dataAddr = {ar.bankSelectReg, ar.fileAddr}; // RL8
		end else if (ar.extEnable && (ar.fileAddr <= tsw_pkg::INDEX_LIMIT)) begin
			// wraps within data space rather than faulting on a large base
			ar.dataAddr = ar.indexBase + {4'h0, ar.fileAddr}; // RL9
			ar.indexed = 1'b1;
		end else if (ar.fileAddr < tsw_pkg::ACCESS_SPLIT) begin
			ar.dataAddr = {tsw_pkg::ACCESS_LOW_BANK, ar.fileAddr}; // RL7
		end else begin
			ar.dataAddr = {tsw_pkg::ACCESS_HIGH_BANK, ar.fileAddr}; // RL7
		end
	end
endmodule

// File: hdl/test_skip_table_write.sv
// Purpose: executes the test-and-skip-if-zero and table write instructions
// Assumes: data memory answers a read in the same cycle as the read strobe
// Notes: instructions offered while busy are ignored; core holds them
// Behaviour
// (RL1) post-increment write: latch byte to holding register at pointer, then pointer plus one
// (RL2) pre-increment write: pointer plus one first, then latch byte to new address
// (RL3) table write leaves latch unchanged, writes only the one addressed holding byte
// (RL4) test-and-skip takes an 8-bit file address and one access bit
// (RL5) zero operand discards the prefetched instruction, runs a no-op, two cycles
// (RL6) skip is a substituted no-op; no status flags change
// (RL7) opcode 0110011 plus access bit and address; access bit 0 picks access bank
// (RL8) access bit 1 uses the bank select register for the bank
// (RL9) access bit 0 with extended set and address up to 5Fh is indexed
// (RL10) nonzero operand lets the prefetched instruction run; one execute cycle
`timescale 1ns/1ps
module test_skip_table_write (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	// instruction pipeline
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	output logic busy_q,
	output logic flushPrefetch_q,
	output logic execDone_q,
	output logic statusWrEn_q,
	// addressing context
	input wire logic [3:0] bank_select_reg,
	input wire logic extendedEn,
	input wire logic [tsw_pkg::DATA_AW-1:0] indexBase,
	// data memory read
	output logic dataRdEn_q,
	output logic [tsw_pkg::DATA_AW-1:0] dataRdAddr_q,
	output logic dataIndexed_q,
	input wire logic [7:0] dataRdData,
	// table write path
	input wire logic [7:0] table_latch,
	input wire logic ptrLoad,
	input wire logic [tsw_pkg::PTR_W-1:0] ptrLoadValue,
	output logic [tsw_pkg::PTR_W-1:0] table_pointer_q,
	output logic holdWrEn_q,
	output logic [tsw_pkg::PTR_W-1:0] holdWrAddr_q,
	output logic [7:0] holdWrData_q
);
	tsw_pkg::exec_state_t state_q;
	addr_res_if ar ();
	logic isSkip;
	logic isTblWr;
	logic [1:0] twMode;
	logic [tsw_pkg::PTR_W-1:0] ptrNext;

	operand_addr_resolver u_resolver (
		.ar(ar)
	);

	assign ar.fileAddr = instrWord[7:0]; // RL4
	assign ar.accessBit = instrWord[8]; // RL4
	assign ar.bankSelectReg = bank_select_reg;
	assign ar.extEnable = extendedEn;
	assign ar.indexBase = indexBase;

	assign isSkip = instrValid && (instrWord[15:9] == tsw_pkg::SKIP_OPC) && (state_q == tsw_pkg::ST_IDLE); // RL7
	assign isTblWr = instrValid && (instrWord[15:4] == tsw_pkg::TBLWR_OPC) && (state_q == tsw_pkg::ST_IDLE);
	assign twMode = instrWord[1:0];
	assign ptrNext = table_pointer_q + tsw_pkg::PTR_STEP;

	// skip sequencing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= tsw_pkg::ST_IDLE;
			dataRdEn_q <= 1'b0;
			dataRdAddr_q <= '0;
			dataIndexed_q <= 1'b0;
			flushPrefetch_q <= 1'b0;
			execDone_q <= 1'b0;
		end else if (clkEn) begin
			dataRdEn_q <= 1'b0;
			flushPrefetch_q <= 1'b0;
			execDone_q <= 1'b0;
			unique case (state_q)
				tsw_pkg::ST_IDLE: begin
					if (isSkip) begin
						dataRdEn_q <= 1'b1;
						dataRdAddr_q <= ar.dataAddr;
						dataIndexed_q <= ar.indexed;
						state_q <= tsw_pkg::ST_READ;
					end
				end
				tsw_pkg::ST_READ: begin
					if (dataRdData == 8'h00) begin
						flushPrefetch_q <= 1'b1; // RL5
						state_q <= tsw_pkg::ST_SKIP;
					end else begin
						execDone_q <= 1'b1; // RL10
						state_q <= tsw_pkg::ST_IDLE;
					end
				end
				tsw_pkg::ST_SKIP: begin
					// the flushed slot executes as a no-op here
					execDone_q <= 1'b1; // RL6
					state_q <= tsw_pkg::ST_IDLE;
				end
				default: begin
					state_q <= tsw_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// busy and status: this block never writes status flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
			statusWrEn_q <= 1'b0;
		end else if (clkEn) begin
			busy_q <= isSkip || (state_q == tsw_pkg::ST_READ && dataRdData == 8'h00);
			statusWrEn_q <= 1'b0; // RL6
		end
	end

	// table pointer and holding register write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			table_pointer_q <= '0;
			holdWrEn_q <= 1'b0;
			holdWrAddr_q <= '0;
			holdWrData_q <= 8'h00;
		end else if (clkEn) begin
			holdWrEn_q <= 1'b0;
			if (isTblWr) begin
				holdWrEn_q <= 1'b1; // RL3
				holdWrData_q <= table_latch; // RL3
				unique case (twMode)
					tsw_pkg::TW_PLAIN: begin
						holdWrAddr_q <= table_pointer_q;
					end
					tsw_pkg::TW_POSTINC: begin
						holdWrAddr_q <= table_pointer_q; // RL1
						table_pointer_q <= ptrNext; // RL1
					end
					tsw_pkg::TW_POSTDEC: begin
						holdWrAddr_q <= table_pointer_q;
						table_pointer_q <= table_pointer_q - tsw_pkg::PTR_STEP;
					end
					tsw_pkg::TW_PREINC: begin
						holdWrAddr_q <= ptrNext; // RL2
						table_pointer_q <= ptrNext; // RL2
					end
				endcase
			end else if (ptrLoad) begin
				// a write in the same cycle wins; software reloads after it
				table_pointer_q <= ptrLoadValue;
			end
		end
	end

	property p_postinc;
		@(posedge clk) disable iff (!reset_n)
		(clkEn && isTblWr && twMode == tsw_pkg::TW_POSTINC) |=>
			(holdWrEn_q && holdWrAddr_q == $past(table_pointer_q) && table_pointer_q == $past(table_pointer_q) + 21'h000001);
	endproperty
	a_postinc: assert property (p_postinc) else $error("post-increment write wrong"); // RL1

	property p_preinc;
		@(posedge clk) disable iff (!reset_n)
		(clkEn && isTblWr && twMode == tsw_pkg::TW_PREINC) |=>
			(holdWrAddr_q == $past(table_pointer_q) + 21'h000001 && table_pointer_q == holdWrAddr_q);
	endproperty
	a_preinc: assert property (p_preinc) else $error("pre-increment write wrong"); // RL2

	property p_latch_data;
		@(posedge clk) disable iff (!reset_n)
		(clkEn && isTblWr) |=> (holdWrEn_q && holdWrData_q == $past(table_latch)) ##1
			(!$past(clkEn) || !holdWrEn_q || $past(isTblWr));
	endproperty
	a_latch_data: assert property (p_latch_data) else $error("holding write data or count wrong"); // RL3

	property p_operand;
		@(posedge clk) disable iff (!reset_n)
		(clkEn && isSkip && instrWord[8]) |=> (dataRdEn_q && dataRdAddr_q[7:0] == $past(instrWord[7:0]));
	endproperty
	a_operand: assert property (p_operand) else $error("operand address not taken"); // RL4

	property p_zero_skip;
		@(posedge clk) disable iff (!reset_n)
		(clkEn && state_q == tsw_pkg::ST_READ && dataRdData == 8'h00) ##1 clkEn |=>
			(flushPrefetch_q == 1'b0 && execDone_q && state_q == tsw_pkg::ST_IDLE);
	endproperty
	a_zero_skip: assert property (p_zero_skip) else $error("zero skip not two cycles"); // RL5

	property p_no_status;
		@(posedge clk) disable iff (!reset_n)
		busy_q |-> !statusWrEn_q;
	endproperty
	a_no_status: assert property (p_no_status) else $error("status written"); // RL6

	property p_access_bank;
		@(posedge clk) disable iff (!reset_n)
		(clkEn && isSkip && !instrWord[8] && !extendedEn) |=>
			(dataRdAddr_q[11:8] == ($past(instrWord[7]) ? 4'hf : 4'h0));
	endproperty
	a_access_bank: assert property (p_access_bank) else $error("access bank wrong"); // RL7

	property p_bank_select;
		@(posedge clk) disable iff (!reset_n)
		(clkEn && isSkip && instrWord[8]) |=> (dataRdAddr_q[11:8] == $past(bank_select_reg) && !dataIndexed_q);
	endproperty
	a_bank_select: assert property (p_bank_select) else $error("bank select not used"); // RL8

	property p_indexed;
		@(posedge clk) disable iff (!reset_n)
		(clkEn && isSkip && !instrWord[8] && extendedEn) |=>
			(dataIndexed_q == ($past(instrWord[7:0]) <= 8'h5f));
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed mode choice wrong"); // RL9

	property p_nonzero;
		@(posedge clk) disable iff (!reset_n)
		(clkEn && state_q == tsw_pkg::ST_READ && dataRdData != 8'h00) |=> (execDone_q && !flushPrefetch_q);
	endproperty
	a_nonzero: assert property (p_nonzero) else $error("nonzero operand skipped"); // RL10

	c_skip_taken: cover property (@(posedge clk) disable iff (!reset_n) flushPrefetch_q ##1 execDone_q);
	c_no_skip: cover property (@(posedge clk) disable iff (!reset_n) dataRdEn_q ##1 execDone_q);
	c_preinc: cover property (@(posedge clk) disable iff (!reset_n) clkEn && isTblWr && twMode == tsw_pkg::TW_PREINC);
	c_indexed: cover property (@(posedge clk) disable iff (!reset_n) dataRdEn_q && dataIndexed_q);
endmodule

// File: verif/data_mem_model.sv
// Purpose: data memory answering the skip-test read port
// Assumes: read data is due in the same cycle as the read strobe
// Notes: between reads the line toggles, so stale data never looks valid
`timescale 1ns/1ps
module data_mem_model (
	// clock
	input wire logic clk,
	// read port
	input wire logic rdEn,
	input wire logic [tsw_pkg::DATA_AW-1:0] rdAddr,
	output logic [7:0] rdData
);
	logic [7:0] mem [4096];
	logic [7:0] lastQ = 8'h00;
	assign rdData = rdEn ? mem[rdAddr] : ~lastQ;
	always @(posedge clk) begin
		lastQ <= rdData;
	end
endmodule

// File: verif/testbench.sv
// Purpose: self-checking bench for the skip-test and table write block
// Assumes: clock enable high except in its own case; timing as in the hand-over walks
// Notes: ordinary cases are table rows, awkward cases follow by hand
`timescale 1ns/1ps
module testbench;
	typedef struct {logic a; logic [7:0] f; logic [3:0] bank; logic ext; logic [7:0] val; logic [11:0] addr; logic idx;} skip_row_t;
	typedef struct {logic [1:0] form; logic [20:0] ptr; logic [7:0] lat; logic [20:0] addr; logic [20:0] nxt;} tw_row_t;
	logic clk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, instrValid = 1'b0, extendedEn = 1'b0, ptrLoad = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic [3:0] bank_select_reg = 4'h0;
	logic [11:0] indexBase = 12'h300, dataRdAddr_q;
	logic [7:0] table_latch = 8'h00, dataRdData, holdWrData_q;
	logic [20:0] ptrLoadValue = 21'h000000, table_pointer_q, holdWrAddr_q;
	logic busy_q, flushPrefetch_q, execDone_q, statusWrEn_q, dataRdEn_q, dataIndexed_q, holdWrEn_q;
	int n_errors = 0, tests_run = 0;
	skip_row_t sr [6] = '{'{1, 8'h12, 4'h5, 0, 8'h00, 12'h512, 0}, '{0, 8'h5f, 4'h5, 1, 8'h07, 12'h35f, 1},
		'{0, 8'h60, 4'h5, 1, 8'h00, 12'h060, 0}, '{0, 8'h10, 4'h5, 0, 8'h01, 12'h010, 0},
		'{0, 8'h80, 4'h5, 1, 8'h00, 12'hf80, 0}, '{1, 8'hff, 4'hf, 0, 8'h80, 12'hfff, 0}};
	tw_row_t tr [5] = '{'{2'h1, 21'h00a356, 8'h55, 21'h00a356, 21'h00a357},
		'{2'h3, 21'h01389a, 8'h34, 21'h01389b, 21'h01389b}, '{2'h2, 21'h000010, 8'ha5, 21'h000010, 21'h00000f},
		'{2'h0, 21'h000020, 8'h3c, 21'h000020, 21'h000020}, '{2'h1, 21'h1fffff, 8'hc3, 21'h1fffff, 21'h000000}};
	always #5 clk = ~clk;
	test_skip_table_write i_dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .instrValid(instrValid),
		.instrWord(instrWord), .busy_q(busy_q), .flushPrefetch_q(flushPrefetch_q), .execDone_q(execDone_q),
		.statusWrEn_q(statusWrEn_q), .bank_select_reg(bank_select_reg), .extendedEn(extendedEn),
		.indexBase(indexBase), .dataRdEn_q(dataRdEn_q), .dataRdAddr_q(dataRdAddr_q), .dataIndexed_q(dataIndexed_q),
		.dataRdData(dataRdData), .table_latch(table_latch), .ptrLoad(ptrLoad), .ptrLoadValue(ptrLoadValue),
		.table_pointer_q(table_pointer_q), .holdWrEn_q(holdWrEn_q), .holdWrAddr_q(holdWrAddr_q),
		.holdWrData_q(holdWrData_q));
	data_mem_model i_mem (.clk(clk), .rdEn(dataRdEn_q), .rdAddr(dataRdAddr_q), .rdData(dataRdData));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one-cycle offer; returns just after the taking edge
	task automatic issue(input logic [15:0] w);
		@(posedge clk);
		instrValid <= 1'b1;
		instrWord <= w;
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
	endtask
	task automatic load_ptr(input logic [20:0] p, input logic [7:0] lat);
		@(posedge clk);
		ptrLoad <= 1'b1;
		ptrLoadValue <= p;
		table_latch <= lat;
		@(posedge clk);
		ptrLoad <= 1'b0;
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		chk("busy", busy_q, 0);
		chk("ptr", table_pointer_q, 0);
		chk("holdEn", holdWrEn_q, 0);
		$display("test reset done");
		foreach (sr[i]) begin
			i_mem.mem[sr[i].addr] = sr[i].val;
			@(posedge clk);
			bank_select_reg <= sr[i].bank;
			extendedEn <= sr[i].ext;
			issue({tsw_pkg::SKIP_OPC, sr[i].a, sr[i].f});
			chk("rdEn", dataRdEn_q, 1);
			chk("rdAddr", dataRdAddr_q, sr[i].addr);
			chk("indexed", dataIndexed_q, sr[i].idx);
			chk("busyRd", busy_q, 1);
			@(posedge clk);
			#1;
			chk("flush", flushPrefetch_q, sr[i].val == 8'h00);
			chk("done", execDone_q, sr[i].val != 8'h00);
			chk("busyHold", busy_q, sr[i].val == 8'h00);
			if (sr[i].val == 8'h00) begin
				@(posedge clk);
				#1;
				chk("doneZ", execDone_q, 1);
				chk("busyOff", busy_q, 0);
				chk("flushOff", flushPrefetch_q, 0);
			end
			chk("status", statusWrEn_q, 0);
			$display("test skip %0d done", i);
		end
		foreach (tr[i]) begin
			load_ptr(tr[i].ptr, tr[i].lat);
			issue({tsw_pkg::TBLWR_OPC, 2'h0, tr[i].form});
			chk("holdEn", holdWrEn_q, 1);
			chk("holdAddr", holdWrAddr_q, tr[i].addr);
			chk("holdData", holdWrData_q, tr[i].lat);
			chk("ptr", table_pointer_q, tr[i].nxt);
			@(posedge clk);
			#1;
			chk("holdOnce", holdWrEn_q, 0);
			$display("test table write %0d done", i);
		end
		// back-to-back post-increment writes, with a pointer load that must lose
		load_ptr(21'h000100, 8'h77);
		@(posedge clk);
		instrValid <= 1'b1;
		instrWord <= 16'h0031;
		@(posedge clk);
		ptrLoad <= 1'b1;
		ptrLoadValue <= 21'h0abcde;
		@(posedge clk);
		instrValid <= 1'b0;
		ptrLoad <= 1'b0;
		#1;
		chk("b2bAddr", holdWrAddr_q, 21'h000101);
		chk("b2bPtr", table_pointer_q, 21'h000102);
		$display("test back-to-back done");
		// an instruction offered while a zero skip is busy is ignored
		i_mem.mem[12'h512] = 8'h00;
		bank_select_reg <= 4'h5;
		@(posedge clk);
		instrValid <= 1'b1;
		instrWord <= {tsw_pkg::SKIP_OPC, 1'b1, 8'h12};
		@(posedge clk);
		instrWord <= 16'h0031;
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
		chk("busyFlush", flushPrefetch_q, 1);
		chk("busyHigh", busy_q, 1);
		@(posedge clk);
		#1;
		chk("busyDone", execDone_q, 1);
		chk("ignored", holdWrEn_q, 0);
		chk("ptrKept", table_pointer_q, 21'h000102);
		$display("test refusal done");
		// clock enable low freezes the block mid-instruction, strobe stretches
		i_mem.mem[12'h512] = 8'h09;
		issue({tsw_pkg::SKIP_OPC, 1'b1, 8'h12});
		clkEn <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("frozenRd", dataRdEn_q, 1);
		chk("frozenDone", execDone_q, 0);
		clkEn <= 1'b1;
		@(posedge clk);
		#1;
		chk("thawDone", execDone_q, 1);
		chk("thawFlush", flushPrefetch_q, 0);
		$display("test clock enable done");
		wrap_up();
	end
endmodule
